// *** src/diag_monitor_pkg.sv ***
package diag_monitor_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RESULT_W = 12;
  localparam int POINT_N = 8;
  localparam int POINT_IDX_W = 3;

  // ------------------------------------------------------------
  // register offsets (word index, carried directly on the bus address)
  // ------------------------------------------------------------
  localparam logic [7:0] MIC_BIAS_MONITOR_HIGH_IDX = 8'h58;
  localparam logic [7:0] MIC_BIAS_MONITOR_LOW_IDX = 8'h59;
  localparam logic [7:0] OUT1_POS_MONITOR_HIGH_IDX = 8'h62;
  localparam logic [7:0] OUT1_POS_MONITOR_LOW_IDX = 8'h63;
  localparam logic [7:0] OUT1_NEG_MONITOR_HIGH_IDX = 8'h64;
  localparam logic [7:0] OUT1_NEG_MONITOR_LOW_IDX = 8'h65;
  localparam logic [7:0] OUT2_POS_MONITOR_HIGH_IDX = 8'h66;
  localparam logic [7:0] OUT2_POS_MONITOR_LOW_IDX = 8'h67;
  localparam logic [7:0] OUT2_NEG_MONITOR_HIGH_IDX = 8'h68;
  localparam logic [7:0] OUT2_NEG_MONITOR_LOW_IDX = 8'h69;
  localparam logic [7:0] TEMPERATURE_MONITOR_HIGH_IDX = 8'h6A;
  localparam logic [7:0] TEMPERATURE_MONITOR_LOW_IDX = 8'h6B;
  localparam logic [7:0] BIAS_LOAD_MONITOR_HIGH_IDX = 8'h6C;
  localparam logic [7:0] BIAS_LOAD_MONITOR_LOW_IDX = 8'h6D;
  localparam logic [7:0] ANALOG_SUPPLY_MONITOR_HIGH_IDX = 8'h6E;
  localparam logic [7:0] ANALOG_SUPPLY_MONITOR_LOW_IDX = 8'h6F;
  // control register holding the freeze bit
  localparam logic [7:0] MONITOR_CTRL_IDX = 8'h55;

  // ------------------------------------------------------------
  // fields
  // ------------------------------------------------------------
  localparam int HIGH_FIELD_LSB = 4;
  localparam int LOW_NIBBLE_LSB = 4;
  localparam int FREEZE_BIT = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ------------------------------------------------------------
  // channel identifiers, one per point in point order
  // ------------------------------------------------------------
  localparam logic [3:0] CHAN_MIC_BIAS = 4'h1;
  localparam logic [3:0] CHAN_OUT1_POS = 4'h6;
  localparam logic [3:0] CHAN_OUT1_NEG = 4'h7;
  localparam logic [3:0] CHAN_OUT2_POS = 4'h8;
  localparam logic [3:0] CHAN_OUT2_NEG = 4'h9;
  localparam logic [3:0] CHAN_TEMPERATURE = 4'hA;
  localparam logic [3:0] CHAN_BIAS_LOAD = 4'hB;
  localparam logic [3:0] CHAN_ANALOG_SUPPLY = 4'hC;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage

// *** src/monitor_result_slot.sv ***
`timescale 1ns/100ps
module monitor_result_slot
  import diag_monitor_pkg::*;
#(
  parameter int WIDTH = RESULT_W
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] result_in,
  output logic [WIDTH-1:0] result_out
);
  // whole result word loads at once so the two halves always match
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      result_out <= WIDTH'(RESULT_RESET);
    end
    else if (load_in)
    begin
      result_out <= result_in;
    end
  end
endmodule

// *** src/diag_monitor_readback_regs.sv ***
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
// Function
// - high register returns result bits eleven to four
// - low register bits 7-4 return result bits 3-0
// - mic bias pair 0x58/0x59, identifier 0001b
// - output 1 legs 0x62-0x65, identifiers 0110b/0111b
// - output 2 legs 0x66-0x69, identifiers 1000b/1001b
// - temperature pair 0x6A/0x6B, identifier 1010b
// - bias load pair 0x6C/0x6D, identifier 1011b
// - analog supply pair 0x6E/0x6F, identifier 1100b
// - high byte even address, low next odd
// - freeze bit set holds results; clear updates
module diag_monitor_readback_regs
#(
  parameter int POINTS = diag_monitor_pkg::POINT_N
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [diag_monitor_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [diag_monitor_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [diag_monitor_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic avs_response_out,
  input wire logic conv_valid_in,
  input wire logic [diag_monitor_pkg::POINT_IDX_W-1:0] conv_point_in,
  input wire logic [diag_monitor_pkg::RESULT_W-1:0] conv_result_in,
  output logic freeze_monitor_update_out
);
  import diag_monitor_pkg::*;

  // ------------------------------------------------------------
  // point tables
  // ------------------------------------------------------------
  // word index of each point's high register, in point order
  localparam logic [7:0] HIGH_IDX [POINT_N] = '{
    MIC_BIAS_MONITOR_HIGH_IDX,
    OUT1_POS_MONITOR_HIGH_IDX,
    OUT1_NEG_MONITOR_HIGH_IDX,
    OUT2_POS_MONITOR_HIGH_IDX,
    OUT2_NEG_MONITOR_HIGH_IDX,
    TEMPERATURE_MONITOR_HIGH_IDX,
    BIAS_LOAD_MONITOR_HIGH_IDX,
    ANALOG_SUPPLY_MONITOR_HIGH_IDX
  };

  // word index of each point's low register
  localparam logic [7:0] LOW_IDX [POINT_N] = '{
    MIC_BIAS_MONITOR_LOW_IDX,
    OUT1_POS_MONITOR_LOW_IDX,
    OUT1_NEG_MONITOR_LOW_IDX,
    OUT2_POS_MONITOR_LOW_IDX,
    OUT2_NEG_MONITOR_LOW_IDX,
    TEMPERATURE_MONITOR_LOW_IDX,
    BIAS_LOAD_MONITOR_LOW_IDX,
    ANALOG_SUPPLY_MONITOR_LOW_IDX
  };

  // fixed channel identifier shown in each low register
  localparam logic [3:0] CHAN_ID [POINT_N] = '{
    CHAN_MIC_BIAS,
    CHAN_OUT1_POS,
    CHAN_OUT1_NEG,
    CHAN_OUT2_POS,
    CHAN_OUT2_NEG,
    CHAN_TEMPERATURE,
    CHAN_BIAS_LOAD,
    CHAN_ANALOG_SUPPLY
  };

  logic [RESULT_W-1:0] result [POINTS];
  logic freeze_r;
  bus_state_t state_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic hit_nxt;
  logic [7:0] word_idx;
  // bus handshake
  logic req;
  logic take;
  logic answer;
  // control word decode
  logic ctrl_hit;
  logic ctrl_wr;

  // the bus carries word addresses, so the index is the address itself;
  // a byte address would not reach the upper registers in eight bits
  assign word_idx = avs_address_in;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // control word holding the freeze bit
  function automatic logic ctrl_at(
    input logic [7:0] idx
  );
    return idx == MONITOR_CTRL_IDX;
  endfunction

  // high register of point p
  function automatic logic high_at(
    input logic [7:0] idx,
    input int p
  );
    return idx == HIGH_IDX[p];
  endfunction

  // low register of point p
  function automatic logic low_at(
    input logic [7:0] idx,
    input int p
  );
    return idx == LOW_IDX[p];
  endfunction

  // high image: upper eight result bits
  function automatic logic [7:0] high_image(
    input logic [RESULT_W-1:0] res
  );
    return res[RESULT_W-1:HIGH_FIELD_LSB];
  endfunction

  // low image: lowest result nibble over the channel identifier
  function automatic logic [7:0] low_image(
    input logic [RESULT_W-1:0] res,
    input logic [3:0] id
  );
    return {res[HIGH_FIELD_LSB-1:0], id};
  endfunction

  // control word image: freeze bit in place, other bits zero
  function automatic logic [DATA_W-1:0] ctrl_image(
    input logic frozen
  );
    logic [DATA_W-1:0] img;
    img = '0;
    img[FREEZE_BIT] = frozen;
    return img;
  endfunction

  // a slot loads on a result for its own point unless frozen
  function automatic logic slot_load(
    input logic valid,
    input logic frozen,
    input logic [POINT_IDX_W-1:0] point,
    input int p
  );
    return valid && !frozen && (point == POINT_IDX_W'(p));
  endfunction

  // ------------------------------------------------------------
  // bus request decode
  // ------------------------------------------------------------
  assign req = avs_read_in || avs_write_in;
  // a request is taken in its first cycle and answered in its second
  assign take = req && (state_r == BUS_IDLE);
  assign answer = state_r == BUS_ANSWER;
  assign ctrl_hit = ctrl_at(word_idx);
  assign ctrl_wr = avs_write_in && answer && ctrl_hit &&
                   avs_byteenable_in[0];

  // ------------------------------------------------------------
  // result storage
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < POINTS; g++)
    begin : slot
      logic load;
      assign load = slot_load(conv_valid_in, freeze_r, conv_point_in, g);
      monitor_result_slot #(.WIDTH(RESULT_W)) u_slot (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(load),
        .result_in(conv_result_in),
        .result_out(result[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = '0;
    hit_nxt = 1'b0;
    if (ctrl_hit)
    begin
      rdata_nxt = ctrl_image(freeze_r);
      hit_nxt = 1'b1;
    end
    for (int i = 0; i < POINTS; i++)
    begin
      if (high_at(word_idx, i))
      begin
        rdata_nxt[7:0] = high_image(result[i]);
        hit_nxt = 1'b1;
      end
      if (low_at(word_idx, i))
      begin
        rdata_nxt[7:0] = low_image(result[i], CHAN_ID[i]);
        hit_nxt = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= BUS_IDLE;
    end
    else
    begin
      unique case (state_r)
        BUS_IDLE:
        begin
          if (avs_read_in || avs_write_in)
          begin
            state_r <= BUS_ANSWER;
          end
        end
        BUS_ANSWER:
        begin
          state_r <= BUS_IDLE;
        end
        default:
        begin
          state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest_out = req && !answer;

  // read data captured as the request is taken, standing until the next
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      avs_readdata_out <= '0;
    end
    else if (take)
    begin
      avs_readdata_out <= avs_read_in ? rdata_nxt : '0;
    end
  end

  // unmapped address answers with slave error and zero data
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      avs_response_out <= 1'b0;
    end
    else if (take)
    begin
      avs_response_out <= !hit_nxt;
    end
  end

  // ------------------------------------------------------------
  // freeze control
  // ------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      freeze_r <= CTRL_RESET[FREEZE_BIT];
    end
    else if (ctrl_wr)
    begin
      freeze_r <= avs_writedata_in[FREEZE_BIT];
    end
  end

  // ------------------------------------------------------------
  // status output
  // ------------------------------------------------------------
  // lets the converter side see that results are being held
  assign freeze_monitor_update_out = freeze_r;

endmodule

// *** tb/diag_monitor_properties.sv ***
`timescale 1ns/100ps
module diag_monitor_checker
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic avs_response_out,
  input wire logic freeze_monitor_update_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  wire logic req = avs_read_in | avs_write_in;
  sequence ctl_wr;
    avs_write_in && avs_address_in == 8'h55 && avs_byteenable_in[0]
      && !avs_waitrequest_out;
  endsequence
  sequence rd_done;
    avs_read_in && !avs_waitrequest_out;
  endsequence
  wait_one_a: assert property (req && avs_waitrequest_out |=>
    !avs_waitrequest_out) else $error("wait longer than one cycle");
  wait_first_a: assert property (req && !$past(req) |->
    avs_waitrequest_out) else $error("no wait in first cycle");
  upper_zero_a: assert property (rd_done |->
    avs_readdata_out[31:8] == 24'h0) else $error("upper bits set");
  id_nibble_a: assert property (rd_done |->
    !(avs_address_in[0] && (avs_address_in == 8'h59
    || avs_address_in inside {[8'h63:8'h6F]}))
    || avs_readdata_out[3:0] == avs_address_in[4:1] + 4'h5)
    else $error("channel id wrong");
  unmapped_a: assert property (rd_done ##0 avs_address_in == 8'h57
    |-> avs_response_out && avs_readdata_out == 32'h0)
    else $error("unmapped read not refused");
  freeze_set_a: assert property (ctl_wr |=>
    freeze_monitor_update_out == $past(avs_writedata_in[0]))
    else $error("freeze not written");
  freeze_hold_a: assert property (!(avs_write_in
    && avs_address_in == 8'h55) |=> $stable(freeze_monitor_update_out))
    else $error("freeze changed without write");
  data_stand_a: assert property (!req |=>
    $stable(avs_readdata_out)) else $error("read data moved");
endmodule
bind diag_monitor_readback_regs diag_monitor_checker u_chk (.*);

// *** tb/diag_monitor_readback_regs_tb.sv ***
`timescale 1ns/100ps
module diag_monitor_readback_regs_tb;
  import diag_monitor_pkg::*;
  logic clk_in = 0;
  logic sys_rst_in = 1;
  logic [7:0] adr = 0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 0;
  logic [3:0] be = 4'hF;
  logic cv = 0;
  logic [2:0] cp = 0;
  logic [11:0] cr = 0;
  logic [31:0] q;
  logic wq;
  logic rs;
  logic fz;
  logic [31:0] rdata;
  logic rresp;
  logic [11:0] m [8];
  logic fm = 0;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  int p;
  diag_monitor_readback_regs u_dut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(q), .avs_waitrequest_out(wq),
    .avs_response_out(rs), .conv_valid_in(cv), .conv_point_in(cp),
    .conv_result_in(cr), .freeze_monitor_update_out(fz));
  function automatic logic [7:0] hi_a(int n);
    return n == 0 ? 8'h58 : 8'h60 + 8'(2 * n);
  endfunction
  function automatic logic [3:0] cid(int n);
    return n == 0 ? 4'h1 : 4'(n + 5);
  endfunction
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk_in); while (wq !== 1'b0);
    rdata = q;
    rresp = rs;
    rd <= 0;
    wr <= 0;
    @(posedge clk_in);
  endtask
  task automatic conv(input int n, input logic [11:0] v);
    cv <= 1;
    cp <= 3'(n);
    cr <= v;
    @(posedge clk_in);
    cv <= 0;
    if (!fm)
      m[n] = v;
  endtask
  task automatic chkpt(input int n);
    bus(0, hi_a(n), 0);
    chk(rdata, {24'h0, m[n][11:4]});
    bus(0, hi_a(n) + 8'h1, 0);
    chk(rdata, {24'h0, m[n][3:0], cid(n)});
  endtask
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    i = $urandom(32'hD253);
    for (i = 0; i < 8; i++)
      m[i] = 12'h000;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 0;
    @(posedge clk_in);
    for (i = 0; i < 8; i++)
      chkpt(i);
    bus(0, 8'h55, 0);
    chk(rdata, 32'h0);
    for (i = 0; i < 40; i++)
    begin
      p = $urandom_range(7);
      conv(p, i < 2 ? {12{i[0]}} : 12'($urandom));
      bus(1, hi_a(p), 32'hFFFFFFFF);
      chkpt(p);
    end
    bus(1, 8'h55, 32'h1);
    fm = 1;
    chk({31'h0, fz}, 32'h1);
    conv(5, 12'hABC);
    chkpt(5);
    be <= 4'h0;
    bus(1, 8'h55, 0);
    chk({31'h0, fz}, 32'h1);
    be <= 4'hF;
    bus(1, 8'h55, 0);
    fm = 0;
    conv(5, 12'h5A3);
    chkpt(5);
    bus(0, 8'h57, 0);
    chk({rdata[30:0], rresp}, 32'h1);
    tally_and_finish();
  end
endmodule
